// >>> fpg_pkg.sv
`default_nettype none
package fpg_pkg;
   // APB register byte offsets.
   localparam logic [7:0] OFS_STAT = 8'h00;
   localparam logic [7:0] OFS_DIV = 8'h04;
   localparam logic [7:0] OFS_CFG = 8'h08;
   localparam logic [7:0] OFS_CMD = 8'h0c;
   localparam logic [7:0] OFS_PROT = 8'h10;
   localparam logic [7:0] OFS_OPT = 8'h14;
   // Printed addresses of the nonvolatile option bytes inside the array.
   localparam logic [15:0] ADDR_PROT_OPTION_BYTE = 16'hffbd;
   localparam logic [15:0] ADDR_OPTION_BYTE = 16'hffbf;
   // Status register fields.
   localparam int ST_CBEF = 7;
   localparam int ST_CCF = 6;
   localparam int ST_PVIOL = 5;
   localparam int ST_ACCERR = 4;
   // Divider register fields.
   localparam int DIV_LOADED = 7;
   localparam logic [7:0] DIV_RESET = 8'h00;
   // Config register fields.
   localparam int CFG_KEY_ACCESS_BIT = 5;
   // Protection byte fields.
   localparam int PROT_DIS = 0;
   localparam logic [8:0] PROT_LOW_ONES = 9'h1ff;
   // Option byte fields.
   localparam int OPT_KEY_ENABLE_BIT = 7;
   localparam int OPT_NORED = 6;
   localparam logic [1:0] SEC_OPEN = 2'b10;
   // Command codes.
   localparam logic [7:0] CMD_BLANK = 8'h05;
   localparam logic [7:0] CMD_BYTE = 8'h20;
   localparam logic [7:0] CMD_BURST = 8'h25;
   localparam logic [7:0] CMD_PAGE = 8'h40;
   localparam logic [7:0] CMD_MASS = 8'h41;
   // Memory map.
   localparam logic [15:0] FLASH_BASE = 16'he000;
   localparam logic [15:0] KEY_BASE = 16'hffb0;
   localparam logic [15:0] VEC_LO = 16'hffc0;
   localparam logic [15:0] VEC_HI = 16'hfffd;
   localparam int KEY_BYTES = 8;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_ADDR, SEQ_CMD} fpg_seq_e;
endpackage
`default_nettype wire

// >>> fpg_guard.sv
// Contract
// - Access error stays set until written 1; no command processed while set.
// - Array write before first divider write sets access error.
// - Array write while command buffer not empty sets access error.
// - Second array write or command write before launch sets access error.
// - Non-command control write after array write sets access error.
// - Command code outside the five valid codes sets access error.
// - After command write, any write but launching status write sets access error.
// - Stop entry during program or erase aborts it and sets access error.
// - Secured debug writes of program or page erase codes set access error.
// - Writing 0 to buffer-empty flag mid-sequence cancels and sets access error.
// - Program and erase above last unprotected address are blocked.
// - Protection active only when the disable bit is 0.
// - Protection loaded from option byte; only debug writes change it.
// - Vectors redirected when allowed and partly protected; reset vector never.
// - Secured: insecure core writes ignored, debug writes pass; insecure or debug reads zero.
// - Security bits copied at reset; only 1:0 means unsecured.
// - Key enable bit 0 disables the backdoor unlock.
// - With key access set, key-location writes are key values.
// - Matching key on key access clear unsecures until reset.
// - Only secure code may enter the key; debug entry never unlocks.
// - Debug blank check finding flash erased unsecures until reset.
// - Command codes are 05, 20, 25, 40, 41; code is latched.
// - Writing 1 to buffer-empty flag launches latched command and clears flag.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module fpg_guard (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic apb_from_debug,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Memory bus from core and debug controller
   input wire logic mem_wr,
   input wire logic mem_rd,
   input wire logic [15:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   input wire logic mem_from_debug,
   input wire logic mem_from_secure,
   input wire logic [7:0] mem_rdata_raw,
   output logic [7:0] mem_rdata,
   output logic mem_rvalid,
   // Vector fetch
   input wire logic vec_req,
   input wire logic [15:0] vec_addr,
   output logic [15:0] vec_addr_out,
   // Nonvolatile copies
   input wire logic [7:0] nv_prot,
   input wire logic [7:0] nv_opt,
   input wire logic [63:0] nv_key,
   // Command sequencer
   input wire logic seq_done,
   input wire logic seq_blank_ok,
   input wire logic stop_entry,
   output logic seq_launch,
   output logic [7:0] seq_cmd,
   output logic [15:0] seq_addr,
   output logic [7:0] seq_data,
   output logic seq_abort,
   // Security state
   output logic secured
);
   logic rs1_ff, rst_n;
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rs1_ff <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rs1_ff <= 1'b1;
         rst_n <= rs1_ff;
      end
   end

   fpg_pkg::fpg_seq_e seq_ff, nxt_seq;
   logic [7:0] stat_ff, nxt_stat, div_ff, nxt_div, cfg_ff, nxt_cfg, prot_ff, nxt_prot, opt_ff, nxt_opt;
   logic [7:0] cmd_ff, nxt_cmd, data_ff, nxt_data;
   logic [15:0] addr_ff, nxt_addr;
   logic cmd_dbg_ff, nxt_cmd_dbg, busy_ff, nxt_busy, unlock_ff, nxt_unlock, load_ff, nxt_load;
   logic [63:0] key_ff, nxt_key;
   logic [3:0] kidx_ff, nxt_kidx;
   logic kbad_ff, nxt_kbad;
   logic launch_ff, nxt_launch, abort_ff, nxt_abort;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
   logic [7:0] mrd_ff, nxt_mrd;
   logic mrv_ff, nxt_mrv, sec_ff, nxt_sec;
   logic [15:0] vec_ff, nxt_vec;

   logic [15:0] last_open;
   logic prot_on, sec_now, blocked, key_hit, wr_acc, rd_setup, mapped, valid_code, code_denied, err_src;
   logic [7:0] wb;

   // Last unprotected address is the select bits with all lower bits forced to 1.
   assign last_open = {prot_ff[7:1], fpg_pkg::PROT_LOW_ONES};
   assign prot_on = !prot_ff[fpg_pkg::PROT_DIS];
   assign sec_now = (opt_ff[1:0] != fpg_pkg::SEC_OPEN) && !unlock_ff;
   assign blocked = sec_now && (mem_from_debug || !mem_from_secure);
   assign key_hit = cfg_ff[fpg_pkg::CFG_KEY_ACCESS_BIT] && (mem_addr >= fpg_pkg::KEY_BASE)
      && (mem_addr < fpg_pkg::KEY_BASE + 16'h0008);
   assign wr_acc = psel && penable && pwrite && pready_ff;
   assign rd_setup = psel && !penable;
   assign mapped = (paddr <= fpg_pkg::OFS_OPT) && (paddr[1:0] == 2'b00);
   assign wb = pwdata[7:0];
   assign valid_code = (wb == fpg_pkg::CMD_BLANK) || (wb == fpg_pkg::CMD_BYTE) || (wb == fpg_pkg::CMD_BURST)
      || (wb == fpg_pkg::CMD_PAGE) || (wb == fpg_pkg::CMD_MASS);
   assign code_denied = sec_now && apb_from_debug && ((wb == fpg_pkg::CMD_BYTE) || (wb == fpg_pkg::CMD_BURST)
      || (wb == fpg_pkg::CMD_PAGE));

   always_comb begin
      nxt_seq = seq_ff;
      nxt_stat = stat_ff;
      nxt_div = div_ff;
      nxt_cfg = cfg_ff;
      nxt_prot = prot_ff;
      nxt_opt = opt_ff;
      nxt_cmd = cmd_ff;
      nxt_data = data_ff;
      nxt_addr = addr_ff;
      nxt_cmd_dbg = cmd_dbg_ff;
      nxt_busy = busy_ff;
      nxt_unlock = unlock_ff;
      nxt_load = 1'b0;
      nxt_key = key_ff;
      nxt_kidx = kidx_ff;
      nxt_kbad = kbad_ff;
      nxt_launch = 1'b0;
      nxt_abort = 1'b0;
      err_src = 1'b0;
      // Option bytes are caught on the first edge after reset release.
      if (load_ff) begin
         nxt_prot = nv_prot;
         nxt_opt = nv_opt;
      end
      // Sequencer completion and stop entry.
      if (busy_ff && seq_done) begin
         nxt_busy = 1'b0;
         nxt_stat[fpg_pkg::ST_CCF] = 1'b1;
         nxt_stat[fpg_pkg::ST_CBEF] = 1'b1;
         if (seq_blank_ok && cmd_dbg_ff && cmd_ff == fpg_pkg::CMD_BLANK) begin
            nxt_unlock = 1'b1;
         end
      end
      if (busy_ff && stop_entry && cmd_ff != fpg_pkg::CMD_BLANK) begin
         nxt_busy = 1'b0;
         nxt_abort = 1'b1;
         err_src = 1'b1;
         nxt_stat[fpg_pkg::ST_CCF] = 1'b1;
         nxt_stat[fpg_pkg::ST_CBEF] = 1'b1;
      end
      // Array writes: key entry or first step of a command.
      if (mem_wr && key_hit) begin
         if (mem_from_debug || !mem_from_secure || kidx_ff >= 4'(fpg_pkg::KEY_BYTES)
            || mem_addr[2:0] != kidx_ff[2:0]) begin
            nxt_kbad = 1'b1;
         end else begin
            nxt_key[kidx_ff[2:0]*8 +: 8] = mem_wdata;
         end
         nxt_kidx = kidx_ff + 4'h1;
      end else if (mem_wr && (!blocked || mem_from_debug) && mem_addr >= fpg_pkg::FLASH_BASE
         && !stat_ff[fpg_pkg::ST_ACCERR]) begin
         if (!div_ff[fpg_pkg::DIV_LOADED] || !stat_ff[fpg_pkg::ST_CBEF] || seq_ff != fpg_pkg::SEQ_IDLE) begin
            err_src = 1'b1;
            nxt_seq = fpg_pkg::SEQ_IDLE;
         end else begin
            nxt_addr = mem_addr;
            nxt_data = mem_wdata;
            nxt_seq = fpg_pkg::SEQ_ADDR;
         end
      end
      // Register writes.
      if (wr_acc && mapped) begin
         case (paddr)
            fpg_pkg::OFS_STAT: begin
               if (wb[fpg_pkg::ST_ACCERR]) begin
                  nxt_stat[fpg_pkg::ST_ACCERR] = 1'b0;
               end
               if (wb[fpg_pkg::ST_PVIOL]) begin
                  nxt_stat[fpg_pkg::ST_PVIOL] = 1'b0;
               end
               if (seq_ff == fpg_pkg::SEQ_ADDR || (seq_ff == fpg_pkg::SEQ_CMD && !wb[fpg_pkg::ST_CBEF])) begin
                  err_src = 1'b1;
                  nxt_seq = fpg_pkg::SEQ_IDLE;
               end else if (seq_ff == fpg_pkg::SEQ_CMD && !stat_ff[fpg_pkg::ST_ACCERR]) begin
                  nxt_seq = fpg_pkg::SEQ_IDLE;
                  if (prot_on && ((cmd_ff == fpg_pkg::CMD_MASS) || (cmd_ff != fpg_pkg::CMD_BLANK
                     && addr_ff > last_open))) begin
                     nxt_stat[fpg_pkg::ST_PVIOL] = 1'b1;
                  end else begin
                     nxt_launch = 1'b1;
                     nxt_busy = 1'b1;
                     nxt_cmd_dbg = apb_from_debug;
                     nxt_stat[fpg_pkg::ST_CBEF] = 1'b0;
                     nxt_stat[fpg_pkg::ST_CCF] = 1'b0;
                  end
               end
            end
            fpg_pkg::OFS_CMD: begin
               if (seq_ff != fpg_pkg::SEQ_ADDR || !valid_code || code_denied) begin
                  err_src = 1'b1;
                  nxt_seq = fpg_pkg::SEQ_IDLE;
               end else begin
                  nxt_cmd = wb;
                  nxt_seq = fpg_pkg::SEQ_CMD;
               end
            end
            default: begin
               if (seq_ff != fpg_pkg::SEQ_IDLE) begin
                  err_src = 1'b1;
                  nxt_seq = fpg_pkg::SEQ_IDLE;
               end else if (paddr == fpg_pkg::OFS_DIV) begin
                  if (!div_ff[fpg_pkg::DIV_LOADED] && !stat_ff[fpg_pkg::ST_ACCERR]) begin
                     nxt_div = {1'b1, wb[6:0]};
                  end
               end else if (paddr == fpg_pkg::OFS_CFG) begin
                  nxt_cfg[fpg_pkg::CFG_KEY_ACCESS_BIT] = wb[fpg_pkg::CFG_KEY_ACCESS_BIT];
                  if (wb[fpg_pkg::CFG_KEY_ACCESS_BIT] && !cfg_ff[fpg_pkg::CFG_KEY_ACCESS_BIT]) begin
                     nxt_kidx = 4'h0;
                     nxt_kbad = 1'b0;
                  end
                  if (!wb[fpg_pkg::CFG_KEY_ACCESS_BIT] && cfg_ff[fpg_pkg::CFG_KEY_ACCESS_BIT] && opt_ff[fpg_pkg::OPT_KEY_ENABLE_BIT]
                     && !kbad_ff && kidx_ff == 4'(fpg_pkg::KEY_BYTES) && key_ff == nv_key) begin
                     nxt_unlock = 1'b1;
                  end
               end else if (paddr == fpg_pkg::OFS_PROT && apb_from_debug) begin
                  nxt_prot = wb;
               end
            end
         endcase
      end
      if (err_src) begin
         nxt_stat[fpg_pkg::ST_ACCERR] = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         seq_ff <= fpg_pkg::SEQ_IDLE;
         stat_ff <= 8'hc0;
         div_ff <= fpg_pkg::DIV_RESET;
         cfg_ff <= 8'h00;
         prot_ff <= 8'hff;
         opt_ff <= 8'hff;
         cmd_ff <= 8'h00;
         data_ff <= 8'h00;
         addr_ff <= 16'h0000;
         cmd_dbg_ff <= 1'b0;
         busy_ff <= 1'b0;
         unlock_ff <= 1'b0;
         load_ff <= 1'b1;
         key_ff <= 64'h0;
         kidx_ff <= 4'h0;
         kbad_ff <= 1'b0;
         launch_ff <= 1'b0;
         abort_ff <= 1'b0;
      end else begin
         seq_ff <= nxt_seq;
         stat_ff <= nxt_stat;
         div_ff <= nxt_div;
         cfg_ff <= nxt_cfg;
         prot_ff <= nxt_prot;
         opt_ff <= nxt_opt;
         cmd_ff <= nxt_cmd;
         data_ff <= nxt_data;
         addr_ff <= nxt_addr;
         cmd_dbg_ff <= nxt_cmd_dbg;
         busy_ff <= nxt_busy;
         unlock_ff <= nxt_unlock;
         load_ff <= nxt_load;
         key_ff <= nxt_key;
         kidx_ff <= nxt_kidx;
         kbad_ff <= nxt_kbad;
         launch_ff <= nxt_launch;
         abort_ff <= nxt_abort;
      end
   end

   // Read data is prepared in the setup cycle so every answer comes with no wait state.
   always_comb begin
      nxt_pready = rd_setup;
      nxt_pslverr = rd_setup && !mapped;
      nxt_prdata = 32'h0;
      if (rd_setup && !pwrite) begin
         case (paddr)
            fpg_pkg::OFS_STAT: nxt_prdata = {24'h0, stat_ff};
            fpg_pkg::OFS_DIV: nxt_prdata = {24'h0, div_ff};
            fpg_pkg::OFS_CFG: nxt_prdata = {24'h0, cfg_ff};
            fpg_pkg::OFS_CMD: nxt_prdata = {24'h0, cmd_ff};
            fpg_pkg::OFS_PROT: nxt_prdata = {24'h0, prot_ff};
            fpg_pkg::OFS_OPT: nxt_prdata = {24'h0, opt_ff[7:2], sec_now ? opt_ff[1:0] : fpg_pkg::SEC_OPEN};
            default: nxt_prdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         prdata_ff <= 32'h0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   // Memory read gating, vector redirection and the security output.
   always_comb begin
      nxt_mrv = mem_rd;
      nxt_mrd = (mem_rd && !blocked) ? mem_rdata_raw : 8'h00;
      nxt_sec = sec_now;
      nxt_vec = vec_ff;
      if (vec_req) begin
         nxt_vec = vec_addr;
         // Fully protected flash leaves no unprotected page to hold the copies.
         if (!opt_ff[fpg_pkg::OPT_NORED] && prot_on && last_open >= fpg_pkg::FLASH_BASE
            && vec_addr >= fpg_pkg::VEC_LO && vec_addr <= fpg_pkg::VEC_HI) begin
            nxt_vec = {last_open[15:6], vec_addr[5:0]};
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mrd_ff <= 8'h00;
         mrv_ff <= 1'b0;
         sec_ff <= 1'b1;
         vec_ff <= 16'h0000;
      end else begin
         mrd_ff <= nxt_mrd;
         mrv_ff <= nxt_mrv;
         sec_ff <= nxt_sec;
         vec_ff <= nxt_vec;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign mem_rdata = mrd_ff;
   assign mem_rvalid = mrv_ff;
   assign vec_addr_out = vec_ff;
   assign seq_launch = launch_ff;
   assign seq_cmd = cmd_ff;
   assign seq_addr = addr_ff;
   assign seq_data = data_ff;
   assign seq_abort = abort_ff;
   assign secured = sec_ff;

   sequence s_cmd_write_bad;
      wr_acc && paddr == fpg_pkg::OFS_CMD && !valid_code;
   endsequence
   sequence s_armed_launch;
      seq_ff == fpg_pkg::SEQ_CMD && wr_acc && paddr == fpg_pkg::OFS_STAT && wb[fpg_pkg::ST_CBEF];
   endsequence

   a_err_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
      stat_ff[fpg_pkg::ST_ACCERR] && !(wr_acc && paddr == fpg_pkg::OFS_STAT && wb[fpg_pkg::ST_ACCERR])
      |=> stat_ff[fpg_pkg::ST_ACCERR]) else $error("access error dropped without clear");
   a_no_launch_err: assert property (@(posedge clk_sys) disable iff (!rst_n)
      stat_ff[fpg_pkg::ST_ACCERR] |=> !launch_ff) else $error("launch while access error set");
   a_nodiv_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
      mem_wr && !key_hit && !blocked && mem_addr >= fpg_pkg::FLASH_BASE && !div_ff[fpg_pkg::DIV_LOADED]
      |=> stat_ff[fpg_pkg::ST_ACCERR]) else $error("write before divider not flagged");
   a_bad_code: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_cmd_write_bad |=> stat_ff[fpg_pkg::ST_ACCERR] && seq_ff == fpg_pkg::SEQ_IDLE)
      else $error("invalid command code accepted");
   a_stop_abort: assert property (@(posedge clk_sys) disable iff (!rst_n)
      busy_ff && stop_entry && cmd_ff != fpg_pkg::CMD_BLANK
      |=> seq_abort && stat_ff[fpg_pkg::ST_ACCERR] ##1 !seq_abort) else $error("stop entry did not abort");
   a_launch_clears: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_armed_launch ##0 !stat_ff[fpg_pkg::ST_ACCERR] ##0 !nxt_stat[fpg_pkg::ST_PVIOL]
      |=> seq_launch && !stat_ff[fpg_pkg::ST_CBEF] ##1 !seq_launch) else $error("launch not taken");
   a_protect_block: assert property (@(posedge clk_sys) disable iff (!rst_n)
      seq_launch && prot_on |-> seq_cmd == fpg_pkg::CMD_BLANK
      || (seq_cmd != fpg_pkg::CMD_MASS && seq_addr <= last_open)) else $error("protected region launched");
   a_secure_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
      mem_rd && blocked |=> mem_rvalid && mem_rdata == 8'h00) else $error("secured read leaked data");
   a_unlock_stays: assert property (@(posedge clk_sys) disable iff (!rst_n)
      unlock_ff |=> unlock_ff) else $error("unlock lost before reset");
   a_key_enable_bit_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
      !opt_ff[fpg_pkg::OPT_KEY_ENABLE_BIT] && !unlock_ff && !(busy_ff && seq_done) |=> !unlock_ff)
      else $error("unlock with key disabled");
   a_reset_vector: assert property (@(posedge clk_sys) disable iff (!rst_n)
      vec_req && vec_addr > fpg_pkg::VEC_HI |=> vec_addr_out == $past(vec_addr))
      else $error("reset vector redirected");
endmodule
`default_nettype wire

// >>> fpg_seq_model.sv
`timescale 1ns/1ns
`default_nettype none
module fpg_seq_model (
   // Clock
   input wire logic clk_sys,
   // Guard side
   input wire logic seq_launch,
   input wire logic seq_abort,
   output logic seq_done,
   output logic seq_blank_ok,
   // Bench control
   input wire logic [4:0] busy_len,
   input wire logic erased
);
   int cnt = 0;
   initial seq_done = 1'b0;
   initial seq_blank_ok = 1'b0;
   // The blank result toggles outside the done pulse, so a guard that samples it late is caught.
   always @(posedge clk_sys) begin
      seq_done <= 1'b0;
      seq_blank_ok <= ~seq_blank_ok;
      if (seq_abort === 1'b1) begin
         cnt <= 0;
      end else if (seq_launch === 1'b1) begin
         cnt <= int'(busy_len) + 1;
      end else if (cnt == 1) begin
         seq_done <= 1'b1;
         seq_blank_ok <= erased;
         cnt <= 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule
`default_nettype wire

// >>> flash_protect_security_guard_bench.sv
`timescale 1ns/1ns
`default_nettype none
module flash_protect_security_guard_bench;
   logic clk_sys = '0, nrst = '0, psel = '0, penable = '0, pwrite = '0, apb_from_debug = '0, err, ok;
   logic mem_wr = '0, mem_rd = '0, mem_from_debug = '0, mem_from_secure = '1, vec_req = '0, stop_entry = '0;
   logic erased = '0, pready, pslverr, mem_rvalid, seq_done, seq_blank_ok, seq_launch, seq_abort, secured;
   logic [7:0] paddr = '0, mem_wdata = '0, mem_rdata_raw = '0, nv_prot = '0, nv_opt = '0;
   logic [7:0] mem_rdata, seq_cmd, seq_data, c;
   logic [15:0] mem_addr = '0, vec_addr = '0, vec_addr_out, seq_addr, a;
   logic [31:0] pwdata = '0, prdata, rdat, lat;
   logic [63:0] nv_key = '0;
   logic [4:0] busy_len = '0;
   logic [7:0] codes [5] = '{fpg_pkg::CMD_BLANK, fpg_pkg::CMD_BYTE, fpg_pkg::CMD_BURST, fpg_pkg::CMD_PAGE,
      fpg_pkg::CMD_MASS};
   int failures = 0, tests_run = 0, launches = 0, aborts = 0, n0;
   fpg_guard fpg_guard_inst (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .apb_from_debug, .prdata,
      .pready, .pslverr, .mem_wr, .mem_rd, .mem_addr, .mem_wdata, .mem_from_debug, .mem_from_secure, .mem_rdata_raw,
      .mem_rdata, .mem_rvalid, .vec_req, .vec_addr, .vec_addr_out, .nv_prot, .nv_opt, .nv_key, .seq_done,
      .seq_blank_ok, .stop_entry, .seq_launch, .seq_cmd, .seq_addr, .seq_data, .seq_abort, .secured);
   fpg_seq_model fpg_seq_model_inst (.clk_sys, .seq_launch, .seq_abort, .seq_done, .seq_blank_ok, .busy_len, .erased);
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (seq_launch === 1'b1) begin
         launches++;
         lat = {seq_cmd, seq_addr, seq_data};
      end
      if (seq_abort === 1'b1) aborts++;
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] ad, input logic [7:0] d, input logic dbg);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= {24'h0, d};
      apb_from_debug <= dbg;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      apb(1'b1, ad, d, 1'b0);
   endtask
   task automatic st();
      apb(1'b0, fpg_pkg::OFS_STAT, 8'h00, 1'b0);
   endtask
   task automatic idle_wait();
      int n;
      n = 0;
      do begin
         st();
         n++;
      end while (rdat[7] !== 1'b1 && n < 40);
   endtask
   // The idle cycle after each write keeps key bytes off adjacent bus cycles.
   task automatic memw(input logic [15:0] ad, input logic [7:0] d, input logic dbg);
      mem_wr <= 1'b1;
      mem_addr <= ad;
      mem_wdata <= d;
      mem_from_debug <= dbg;
      mem_from_secure <= ~dbg;
      @(posedge clk_sys);
      mem_wr <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic cmd(input logic [15:0] ad, input logic [7:0] cd, input logic dbg, input logic w);
      memw(ad, 8'($urandom), dbg);
      apb(1'b1, fpg_pkg::OFS_CMD, cd, dbg);
      apb(1'b1, fpg_pkg::OFS_STAT, 8'h80, dbg);
      if (w) idle_wait();
   endtask
   task automatic key(input logic [63:0] k, input logic dbg);
      wr(fpg_pkg::OFS_CFG, 8'h20);
      for (int i = 0; i < 8; i++) memw(fpg_pkg::KEY_BASE + 16'(i), k[8*i +: 8], dbg);
      wr(fpg_pkg::OFS_CFG, 8'h00);
      repeat (3) @(posedge clk_sys);
   endtask
   task automatic vec(input logic [15:0] ad, input logic [15:0] e);
      vec_req <= 1'b1;
      vec_addr <= ad;
      @(posedge clk_sys);
      vec_req <= 1'b0;
      @(negedge clk_sys);
      chk("vector", 32'(e), 32'(vec_addr_out));
      @(posedge clk_sys);
   endtask
   task automatic rdm(input logic dbg, input logic zero);
      logic [7:0] raw;
      raw = 8'($urandom) | 8'h01;
      mem_rd <= 1'b1;
      mem_addr <= 16'he100;
      mem_from_debug <= dbg;
      mem_from_secure <= ~dbg;
      mem_rdata_raw <= raw;
      @(posedge clk_sys);
      mem_rd <= 1'b0;
      @(negedge clk_sys);
      chk("read data", zero ? 32'h0 : 32'(raw), 32'(mem_rdata));
      chk("read valid", 1, mem_rvalid);
      @(posedge clk_sys);
   endtask
   task automatic boot(input logic [7:0] p, input logic [7:0] o);
      nrst <= 1'b0;
      nv_prot <= p;
      nv_opt <= o;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      repeat (8) @(posedge clk_sys);
   endtask
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      results();
   end
   initial begin
      void'($urandom(78));
      nv_key <= {$urandom, $urandom};
      boot(8'hfc, 8'h83);
      chk("secured", 1, secured);
      memw(16'he010, 8'h5a, 1'b0);
      st();
      chk("access error", 1, rdat[4]);
      wr(fpg_pkg::OFS_STAT, 8'h10);
      st();
      chk("access error", 0, rdat[4]);
      wr(fpg_pkg::OFS_DIV, 8'h13);
      apb(1'b0, fpg_pkg::OFS_DIV, 8'h00, 1'b0);
      chk("divider", 32'h93, rdat);
      apb(1'b1, 8'h40, 8'h00, 1'b0);
      chk("slave error", 1, err);
      $display("setup test done");
      for (int i = 0; i < 7; i++) begin
         a = (i == 5) ? 16'hfdff : (i == 6) ? 16'hfe00 : 16'he000 + 16'($urandom % 7680);
         c = (i > 4) ? fpg_pkg::CMD_BYTE : codes[i];
         n0 = launches;
         busy_len <= 5'($urandom);
         cmd(a, c, 1'b0, 1'b1);
         ok = (c != fpg_pkg::CMD_MASS) && (a <= 16'hfdff);
         chk("launches", n0 + ok, launches);
         if (ok) chk("latched", {c, a, mem_wdata}, lat);
         chk("protect violation", !ok, rdat[5]);
         wr(fpg_pkg::OFS_STAT, 8'h20);
      end
      $display("command test done");
      for (int k = 0; k < 8; k++) begin
         n0 = launches;
         busy_len <= 5'd20;
         a = 16'he000 + 16'($urandom % 7680);
         if (k == 7) cmd(a, fpg_pkg::CMD_BYTE, 1'b0, 1'b0);
         memw(a, 8'h33, 1'b0);
         case (k)
            1: begin
               wr(fpg_pkg::OFS_CMD, fpg_pkg::CMD_BYTE);
               wr(fpg_pkg::OFS_CMD, fpg_pkg::CMD_BYTE);
            end
            2: wr(fpg_pkg::OFS_CFG, 8'h00);
            3: wr(fpg_pkg::OFS_CMD, 8'h07);
            4: begin
               wr(fpg_pkg::OFS_CMD, fpg_pkg::CMD_BYTE);
               wr(fpg_pkg::OFS_DIV, 8'h13);
            end
            5: begin
               wr(fpg_pkg::OFS_CMD, fpg_pkg::CMD_BYTE);
               wr(fpg_pkg::OFS_STAT, 8'h00);
            end
            6: apb(1'b1, fpg_pkg::OFS_CMD, fpg_pkg::CMD_BYTE, 1'b1);
            default: ;
         endcase
         wr(fpg_pkg::OFS_STAT, 8'h80);
         idle_wait();
         chk("access error", 1, rdat[4]);
         chk("launches", n0 + (k == 7), launches);
         wr(fpg_pkg::OFS_STAT, 8'h10);
      end
      $display("error test done");
      n0 = aborts;
      cmd(16'he200, fpg_pkg::CMD_BYTE, 1'b0, 1'b0);
      stop_entry <= 1'b1;
      @(posedge clk_sys);
      stop_entry <= 1'b0;
      idle_wait();
      chk("aborts", n0 + 1, aborts);
      chk("access error", 1, rdat[4]);
      wr(fpg_pkg::OFS_STAT, 8'h10);
      vec(16'hffe0, 16'hfde0);
      vec(16'hfffe, 16'hfffe);
      rdm(1'b1, 1'b1);
      rdm(1'b0, 1'b0);
      key(~nv_key, 1'b0);
      chk("secured", 1, secured);
      key(nv_key, 1'b1);
      chk("secured", 1, secured);
      key(nv_key, 1'b0);
      chk("secured", 0, secured);
      st();
      chk("access error", 0, rdat[4]);
      rdm(1'b1, 1'b0);
      $display("key test done");
      wr(fpg_pkg::OFS_PROT, 8'h01);
      apb(1'b0, fpg_pkg::OFS_PROT, 8'h00, 1'b0);
      chk("protection", 32'hfc, rdat);
      apb(1'b1, fpg_pkg::OFS_PROT, 8'hff, 1'b1);
      apb(1'b0, fpg_pkg::OFS_PROT, 8'h00, 1'b0);
      chk("protection", 32'hff, rdat);
      vec(16'hffe0, 16'hffe0);
      n0 = launches;
      cmd(16'hfe00, fpg_pkg::CMD_BYTE, 1'b0, 1'b1);
      chk("launches", n0 + 1, launches);
      $display("protection test done");
      boot(8'hfc, 8'h03);
      key(nv_key, 1'b0);
      chk("secured", 1, secured);
      boot(8'hfc, 8'h42);
      chk("secured", 0, secured);
      vec(16'hffe0, 16'hffe0);
      boot(8'hfc, 8'h83);
      wr(fpg_pkg::OFS_DIV, 8'h13);
      erased <= 1'b1;
      cmd(16'he000, fpg_pkg::CMD_BLANK, 1'b1, 1'b1);
      repeat (3) @(posedge clk_sys);
      chk("secured", 0, secured);
      $display("reset test done");
      results();
   end
endmodule
`default_nettype wire
